// >>> irq_prio_pkg.sv
// Package: map, field layout and types of the interrupt priority-level registers
`default_nettype none
package irq_prio_pkg;
    // ************************************************************
    // Sizes
    // ************************************************************
    localparam int NUM_SRC = 16;
    localparam int NUM_REG = 4;
    localparam int REG_W   = 16;
    localparam int FIELD_W = 2;
    // ************************************************************
    // Register indices; the byte address is four times the index
    // ************************************************************
    localparam logic [1:0] IDX_DEBUG_FIRST    = 2'h0;
    localparam logic [1:0] IDX_DEBUG_SECOND   = 2'h1;
    localparam logic [1:0] IDX_SYSTEM_SOURCES = 2'h2;
    localparam logic [1:0] IDX_PORTS_CAN      = 2'h3;
    localparam int IDX_LSB = 2;
    // ************************************************************
    // Field values and bus answers
    // ************************************************************
    localparam logic [1:0] FIELD_RESET = 2'h0;
    localparam logic [1:0] FIELD_OFF   = 2'h0;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ************************************************************
    // Sources: register, lowest bit and level mapping of each field
    // ************************************************************
    localparam int SRC_BREAK0    = 0;
    localparam int SRC_STEP      = 1;
    localparam int SRC_RX_FULL   = 2;
    localparam int SRC_TX_EMPTY  = 3;
    localparam int SRC_TRACE     = 4;
    localparam int SRC_FLASH_BE  = 5;
    localparam int SRC_FLASH_CC  = 6;
    localparam int SRC_FLASH_ERR = 7;
    localparam int SRC_PLL       = 8;
    localparam int SRC_LOW_VOLT  = 9;
    localparam int SRC_EXT_B     = 10;
    localparam int SRC_EXT_A     = 11;
    localparam int SRC_PORT_D    = 12;
    localparam int SRC_PORT_E    = 13;
    localparam int SRC_PORT_F    = 14;
    localparam int SRC_CAN_MSG   = 15;
    localparam logic [1:0] SRC_REG [NUM_SRC] = '{
        2'h0, 2'h0, 2'h1, 2'h1, 2'h1, 2'h2, 2'h2, 2'h2,
        2'h2, 2'h2, 2'h2, 2'h2, 2'h3, 2'h3, 2'h3, 2'h3};
    localparam int SRC_LSB [NUM_SRC] = '{
        12, 10, 4, 2, 0, 14, 12, 10, 8, 6, 2, 0, 14, 12, 10, 8};
    // One bit per source: set where the field maps to levels 1..3
    localparam logic [NUM_SRC-1:0] SRC_DEBUG = 16'h001f;
    // Writable bits per register; all others read as zero
    localparam logic [REG_W-1:0] REG_MASK [NUM_REG] = '{
        16'h3c00, 16'h003f, 16'hffcf, 16'hff00};
    // ************************************************************
    // Types
    // ************************************************************
    typedef struct packed {
        logic       active;
        logic [1:0] level;
    } irq_req_s;
    typedef enum logic {
        WR_IDLE = 1'b0,
        WR_RESP = 1'b1
    } wr_state_e;
endpackage : irq_prio_pkg
`default_nettype wire

// >>> axil_hold.sv
// One-entry holding slot for an AXI4-Lite address or data channel
`timescale 1ns/1ps
`default_nettype none
module axil_hold #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // Filling side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // Draining side
    output logic              full,
    output logic [W-1:0]      data,
    input  wire logic         take
);
    logic         next_full;
    logic [W-1:0] next_data;

    if (W < 1) begin : g_bad_w
        $error("axil_hold: W must be at least 1");
    end

    // Refuses a new item until the held one is taken, so no item is lost
    assign in_ready = !full;

    always_comb begin
        next_full = full;
        next_data = data;
        if (take) begin
            next_full = 1'b0;
        end
        if (in_valid && in_ready) begin
            next_full = 1'b1;
            next_data = in_data;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            full <= 1'b0;
            data <= '0;
        end else begin
            full <= next_full;
            data <= next_data;
        end
    end
endmodule : axil_hold
`default_nettype wire

// >>> irq_level_decode.sv
// Turns one source's request and priority field into a tagged request
`timescale 1ns/1ps
`default_nettype none
module irq_level_decode #(
    parameter bit DEBUG_MAP = 1'b0
) (
    // Clock and reset
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    // Source and its field
    input  wire logic                 request,
    input  wire logic [1:0]           field,
    // Tagged request toward arbitration
    output irq_prio_pkg::irq_req_s    req_out
);
    irq_prio_pkg::irq_req_s next_req;

    always_comb begin
        next_req = '0;
        if (request && field != irq_prio_pkg::FIELD_OFF) begin
            next_req.active = 1'b1;
            if (DEBUG_MAP) begin
                next_req.level = field;
            end else begin
                next_req.level = field - 2'h1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            req_out <= '0;
        end else begin
            req_out <= next_req;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_debug_levels;
        DEBUG_MAP && request && field != 2'h0 |=> req_out.active && req_out.level == $past(field);
    endproperty
    a_debug_levels: assert property (p_debug_levels) else $error("debug level decode wrong");

    property p_plain_levels;
        !DEBUG_MAP && request && field != 2'h0 |=> req_out.active && req_out.level == $past(field) - 2'h1;
    endproperty
    a_plain_levels: assert property (p_plain_levels) else $error("level decode wrong");

    property p_disabled_silent;
        field == 2'h0 || !request |=> !req_out.active;
    endproperty
    a_disabled_silent: assert property (p_disabled_silent) else $error("disabled source requested");
endmodule : irq_level_decode
`default_nettype wire

// >>> irq_priority_level_regs.sv
// Priority-level registers for sixteen interrupt sources behind AXI4-Lite
// ************************************************************
// ************************************************************
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module irq_priority_level_regs #(
    parameter int AW = 8
) (
    // Clock and reset
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // AXI4-Lite write address
    input  wire logic                  awvalid,
    output logic                       awready,
    input  wire logic [AW-1:0]         awaddr,
    input  wire logic [2:0]            awprot,
    // AXI4-Lite write data
    input  wire logic                  wvalid,
    output logic                       wready,
    input  wire logic [31:0]           wdata,
    input  wire logic [3:0]            wstrb,
    // AXI4-Lite write response
    output logic                       bvalid,
    input  wire logic                  bready,
    output logic [1:0]                 bresp,
    // AXI4-Lite read address
    input  wire logic                  arvalid,
    output logic                       arready,
    input  wire logic [AW-1:0]         araddr,
    input  wire logic [2:0]            arprot,
    // AXI4-Lite read data
    output logic                       rvalid,
    input  wire logic                  rready,
    output logic [31:0]                rdata,
    output logic [1:0]                 rresp,
    // Peripheral request lines, one per source
    input  wire logic [15:0]           src_request,
    // Tagged requests toward the core's arbitration
    output irq_prio_pkg::irq_req_s [15:0] irq_req
);
    localparam int NS = irq_prio_pkg::NUM_SRC;
    localparam int FW = irq_prio_pkg::FIELD_W;
    localparam int IL = irq_prio_pkg::IDX_LSB;

    // Address decode needs at least one bit above the word index
    if (AW < 5) begin : g_bad_aw
        $error("irq_priority_level_regs: AW must be at least 5");
    end

    // ************************************************************
    // Write channel capture
    // ************************************************************
    // Address and data are held apart so they may come in either order
    logic                 aw_full;
    logic [AW-1:0]        aw_addr;
    logic                 w_full;
    logic [35:0]          w_word;
    logic                 wr_fire;

    axil_hold #(
        .W (AW)
    ) u_aw_hold (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .in_valid (awvalid),
        .in_ready (awready),
        .in_data  (awaddr),
        .full     (aw_full),
        .data     (aw_addr),
        .take     (wr_fire)
    );

    axil_hold #(
        .W (36)
    ) u_w_hold (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .in_valid (wvalid),
        .in_ready (wready),
        .in_data  ({wstrb, wdata}),
        .full     (w_full),
        .data     (w_word),
        .take     (wr_fire)
    );

    // ************************************************************
    // Write decode
    // ************************************************************
    logic [31:0]          wr_data;
    logic [3:0]           wr_strb;
    logic [1:0]           wr_idx;
    logic                 wr_hit;

    assign wr_data = w_word[31:0];
    assign wr_strb = w_word[35:32];
    assign wr_idx  = aw_addr[IL +: 2];
    // Anything above the four words, or off word alignment, is unmapped
    assign wr_hit  = (aw_addr[AW-1:IL+2] == '0) && (aw_addr[IL-1:0] == '0);

    // ************************************************************
    // Write response state
    // ************************************************************
    irq_prio_pkg::wr_state_e wr_state;
    irq_prio_pkg::wr_state_e next_wr_state;
    logic [1:0]              next_bresp;

    assign wr_fire = (wr_state == irq_prio_pkg::WR_IDLE) && aw_full && w_full;
    assign bvalid  = (wr_state == irq_prio_pkg::WR_RESP);

    always_comb begin
        next_wr_state = wr_state;
        next_bresp    = bresp;
        case (wr_state)
            irq_prio_pkg::WR_IDLE: begin
                if (wr_fire) begin
                    next_wr_state = irq_prio_pkg::WR_RESP;
                    next_bresp    = wr_hit ? irq_prio_pkg::RESP_OKAY : irq_prio_pkg::RESP_SLVERR;
                end
            end
            irq_prio_pkg::WR_RESP: begin
                if (bready) begin
                    next_wr_state = irq_prio_pkg::WR_IDLE;
                end
            end
            default: begin
                next_wr_state = irq_prio_pkg::WR_IDLE;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state <= irq_prio_pkg::WR_IDLE;
            bresp    <= irq_prio_pkg::RESP_OKAY;
        end else begin
            wr_state <= next_wr_state;
            bresp    <= next_bresp;
        end
    end

    // ************************************************************
    // Priority fields and per-source decode
    // ************************************************************
    // Only named fields are stored, so reserved bits can never be written
    logic [FW-1:0]        field      [NS];
    logic [FW-1:0]        next_field [NS];

    for (genvar i = 0; i < NS; i++) begin : g_src
        always_comb begin
            next_field[i] = field[i];
            if (wr_fire && wr_hit && wr_idx == irq_prio_pkg::SRC_REG[i]
                && wr_strb[irq_prio_pkg::SRC_LSB[i] / 8]) begin
                next_field[i] = wr_data[irq_prio_pkg::SRC_LSB[i] +: FW];
            end
        end

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                field[i] <= irq_prio_pkg::FIELD_RESET;
            end else begin
                field[i] <= next_field[i];
            end
        end

        irq_level_decode #(
            .DEBUG_MAP (irq_prio_pkg::SRC_DEBUG[i])
        ) u_dec (
            .aclk    (aclk),
            .aresetn (aresetn),
            .request (src_request[i]),
            .field   (field[i]),
            .req_out (irq_req[i])
        );
    end

    // ************************************************************
    // Read channel
    // ************************************************************
    logic [1:0]           rd_idx;
    logic                 rd_hit;
    logic [15:0]          rd_word;
    logic                 next_rvalid;
    logic [31:0]          next_rdata;
    logic [1:0]           next_rresp;

    assign rd_idx  = araddr[IL +: 2];
    assign rd_hit  = (araddr[AW-1:IL+2] == '0) && (araddr[IL-1:0] == '0);
    // One read in flight; a new address waits until the data is taken
    assign arready = !rvalid;

    always_comb begin
        rd_word = '0;
        for (int k = 0; k < NS; k++) begin
            if (irq_prio_pkg::SRC_REG[k] == rd_idx) begin
                rd_word[irq_prio_pkg::SRC_LSB[k] +: FW] = field[k];
            end
        end
    end

    always_comb begin
        next_rvalid = rvalid;
        next_rdata  = rdata;
        next_rresp  = rresp;
        if (rvalid && rready) begin
            next_rvalid = 1'b0;
        end
        if (arvalid && arready) begin
            next_rvalid = 1'b1;
            next_rdata  = rd_hit ? {16'h0000, rd_word} : 32'h0000_0000;
            next_rresp  = rd_hit ? irq_prio_pkg::RESP_OKAY : irq_prio_pkg::RESP_SLVERR;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata  <= '0;
            rresp  <= irq_prio_pkg::RESP_OKAY;
        end else begin
            rvalid <= next_rvalid;
            rdata  <= next_rdata;
            rresp  <= next_rresp;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    logic [1:0]           chk_rd_idx;
    logic [2*NS-1:0]      chk_fields;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            chk_rd_idx <= '0;
        end else if (arvalid && arready) begin
            chk_rd_idx <= rd_idx;
        end
    end

    always_comb begin
        chk_fields = '0;
        for (int k = 0; k < NS; k++) begin
            chk_fields[k*FW +: FW] = field[k];
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_reset_clear;
        disable iff (1'b0)
        aresetn && $past(!aresetn) |-> chk_fields == '0;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("field not cleared by reset");

    property p_break0_pos;
        wr_fire && wr_hit && wr_idx == 2'h0 && wr_strb[1] |=> field[0] == $past(wr_data[13:12]);
    endproperty
    a_break0_pos: assert property (p_break0_pos) else $error("breakpoint field misplaced");

    property p_step_pos;
        wr_fire && wr_hit && wr_idx == 2'h0 && wr_strb[1] |=> field[1] == $past(wr_data[11:10]);
    endproperty
    a_step_pos: assert property (p_step_pos) else $error("step counter field misplaced");

    property p_rx_pos;
        wr_fire && wr_hit && wr_idx == 2'h1 && wr_strb[0] |=> field[2] == $past(wr_data[5:4]);
    endproperty
    a_rx_pos: assert property (p_rx_pos) else $error("receive-full field misplaced");

    property p_flash_be_pos;
        wr_fire && wr_hit && wr_idx == 2'h2 && wr_strb[1] |=> field[5] == $past(wr_data[15:14]);
    endproperty
    a_flash_be_pos: assert property (p_flash_be_pos) else $error("flash buffers field misplaced");

    property p_pin_a_pos;
        wr_fire && wr_hit && wr_idx == 2'h2 && wr_strb[0] |=> field[11] == $past(wr_data[1:0]);
    endproperty
    a_pin_a_pos: assert property (p_pin_a_pos) else $error("pin A field misplaced");

    property p_can_pos;
        wr_fire && wr_hit && wr_idx == 2'h3 && wr_strb[1] |=> field[15] == $past(wr_data[9:8]);
    endproperty
    a_can_pos: assert property (p_can_pos) else $error("CAN buffer field misplaced");

    property p_tx_pos;
        wr_fire && wr_hit && wr_idx == 2'h1 && wr_strb[0] |=> field[3] == $past(wr_data[3:2]);
    endproperty
    a_tx_pos: assert property (p_tx_pos) else $error("transmit-empty field misplaced");

    property p_trace_pos;
        wr_fire && wr_hit && wr_idx == 2'h1 && wr_strb[0] |=> field[4] == $past(wr_data[1:0]);
    endproperty
    a_trace_pos: assert property (p_trace_pos) else $error("trace field misplaced");

    property p_flash_cc_pos;
        wr_fire && wr_hit && wr_idx == 2'h2 && wr_strb[1] |=> field[6] == $past(wr_data[13:12]);
    endproperty
    a_flash_cc_pos: assert property (p_flash_cc_pos) else $error("flash complete field misplaced");

    property p_flash_err_pos;
        wr_fire && wr_hit && wr_idx == 2'h2 && wr_strb[1] |=> field[7] == $past(wr_data[11:10]);
    endproperty
    a_flash_err_pos: assert property (p_flash_err_pos) else $error("flash error field misplaced");

    property p_pll_pos;
        wr_fire && wr_hit && wr_idx == 2'h2 && wr_strb[1] |=> field[8] == $past(wr_data[9:8]);
    endproperty
    a_pll_pos: assert property (p_pll_pos) else $error("PLL unlock field misplaced");

    property p_low_volt_pos;
        wr_fire && wr_hit && wr_idx == 2'h2 && wr_strb[0] |=> field[9] == $past(wr_data[7:6]);
    endproperty
    a_low_volt_pos: assert property (p_low_volt_pos) else $error("low-voltage field misplaced");

    property p_port_d_pos;
        wr_fire && wr_hit && wr_idx == 2'h3 && wr_strb[1] |=> field[12] == $past(wr_data[15:14]);
    endproperty
    a_port_d_pos: assert property (p_port_d_pos) else $error("port D field misplaced");

    property p_reserved_zero;
        rvalid |-> rdata[31:16] == 16'h0000
            && (rdata[15:0] & ~irq_prio_pkg::REG_MASK[chk_rd_idx]) == 16'h0000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits read nonzero");

    property p_read_answer;
        arvalid && arready |=> rvalid [*1] ##0 (rresp == irq_prio_pkg::RESP_SLVERR) == !$past(rd_hit);
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read answer wrong");

    c_write: cover property (wr_fire && wr_hit);
    c_read: cover property (rvalid && rready && rresp == irq_prio_pkg::RESP_OKAY);
    c_unmapped: cover property (bvalid && bresp == irq_prio_pkg::RESP_SLVERR);
    c_request: cover property (irq_req[0].active ##1 irq_req[15].active);
endmodule : irq_priority_level_regs
`default_nettype wire

// >>> irq_source_model.sv
// Model of the peripheral request lines feeding the priority-level registers
`timescale 1ns/1ps
`default_nettype none
module irq_source_model (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // Request pattern commanded by the bench
    input  wire logic [15:0] drive,
    // Request levels toward the block
    output logic [15:0]      src_request
);
    // ************************************************************
    // Request levels
    // ************************************************************
    // Peripherals hold their request as a level, launched just after an edge like any flop of the core domain
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            src_request <= 16'h0000;
        end else begin
            src_request <= drive;
        end
    end
endmodule : irq_source_model
`default_nettype wire

// >>> tb_top.sv
// Self-checking testbench for the interrupt priority-level registers
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    // ************************************************************
    // Signals
    // ************************************************************
    logic                         aclk    = 1'b0;
    logic                         aresetn = 1'b0;
    logic                         awvalid = 1'b0;
    logic                         wvalid  = 1'b0;
    logic                         bready  = 1'b0;
    logic                         arvalid = 1'b0;
    logic                         rready  = 1'b0;
    logic [7:0]                   awaddr  = 8'h00;
    logic [7:0]                   araddr  = 8'h00;
    logic [31:0]                  wdata   = 32'h0;
    logic [3:0]                   wstrb   = 4'h0;
    logic [15:0]                  drive   = 16'h0000;
    logic                         awready, wready, bvalid, arready, rvalid;
    logic [31:0]                  rdata;
    logic [1:0]                   bresp, rresp;
    logic [15:0]                  src_request;
    irq_prio_pkg::irq_req_s [15:0] irq_req;
    int                           n_mismatch  = 0;
    int                           comparisons = 0;
    // Field placement of each source: register index and lowest bit
    localparam int          SREG [16] = '{0, 0, 1, 1, 1, 2, 2, 2, 2, 2, 2, 2, 3, 3, 3, 3};
    localparam int          SLSB [16] = '{12, 10, 4, 2, 0, 14, 12, 10, 8, 6, 2, 0, 14, 12, 10, 8};
    localparam logic [15:0] WMASK [4] = '{16'h3c00, 16'h003f, 16'hffcf, 16'hff00};

    always #4 aclk = ~aclk;

    irq_priority_level_regs dut (
        .aclk(aclk), .aresetn(aresetn),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .src_request(src_request), .irq_req(irq_req)
    );

    irq_source_model model (
        .aclk(aclk), .aresetn(aresetn), .drive(drive), .src_request(src_request)
    );

    // ************************************************************
    // Compare and verdict
    // ************************************************************
    task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : check_word

    task automatic check_req(input string what, input irq_prio_pkg::irq_req_s exp, input irq_prio_pkg::irq_req_s got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : check_req

    task automatic give_verdict;
        if (n_mismatch == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict

    // ************************************************************
    // Bus master
    // ************************************************************
    // Handshakes are judged at the falling edge, so the rising edge never races the combinational readies
    task automatic axi_write(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s, output logic [1:0] r);
        logic aw_go, w_go, b_go;
        @(posedge aclk);
        awvalid <= 1'b1;
        awaddr  <= a;
        wvalid  <= 1'b1;
        wdata   <= {16'h0000, d};
        wstrb   <= s;
        bready  <= 1'b1;
        forever begin
            @(negedge aclk);
            aw_go = awvalid && awready;
            w_go  = wvalid && wready;
            b_go  = bvalid;
            r     = bresp;
            @(posedge aclk);
            if (aw_go) awvalid <= 1'b0;
            if (w_go) wvalid <= 1'b0;
            if (b_go) break;
        end
        bready <= 1'b0;
        // The response must be gone once it has been taken
        @(negedge aclk);
        check_word("bvalid", 32'h0, {31'h0, bvalid});
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar_go, r_go;
        @(posedge aclk);
        arvalid <= 1'b1;
        araddr  <= a;
        rready  <= 1'b1;
        forever begin
            @(negedge aclk);
            ar_go = arvalid && arready;
            r_go  = rvalid;
            d     = rdata;
            r     = rresp;
            @(posedge aclk);
            if (ar_go) arvalid <= 1'b0;
            if (r_go) break;
        end
        rready <= 1'b0;
        @(negedge aclk);
        check_word("rvalid", 32'h0, {31'h0, rvalid});
    endtask : axi_read

    task automatic write_ok(input int idx, input logic [15:0] d, input logic [3:0] s);
        logic [1:0] r;
        axi_write(8'(idx * 4), d, s, r);
        check_word("bresp", 32'h0, {30'h0, r});
    endtask : write_ok

    task automatic read_expect(input int idx, input logic [15:0] exp);
        logic [31:0] d;
        logic [1:0]  r;
        axi_read(8'(idx * 4), d, r);
        check_word("rdata", {16'h0000, exp}, d);
        check_word("rresp", 32'h0, {30'h0, r});
    endtask : read_expect

    // Only source src may request, at level lvl; src of -1 means none
    task automatic check_reqs(input int src, input logic [1:0] lvl);
        irq_prio_pkg::irq_req_s exp;
        repeat (3) @(posedge aclk);
        @(negedge aclk);
        for (int j = 0; j < 16; j++) begin
            exp = (j == src) ? {1'b1, lvl} : 3'h0;
            check_req("irq_req", exp, irq_req[j]);
        end
    endtask : check_reqs

    // ************************************************************
    // Tests
    // ************************************************************
    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        drive   <= 16'hffff;
        for (int i = 0; i < 4; i++) read_expect(i, 16'h0000);
        check_reqs(-1, 2'h0);
        for (int i = 0; i < 4; i++) begin
            write_ok(i, 16'hffff, 4'hf);
            read_expect(i, WMASK[i]);
            write_ok(i, 16'h0000, 4'hf);
        end
        write_ok(2, 16'hffff, 4'h1);
        read_expect(2, 16'h00cf);
        write_ok(2, 16'h0000, 4'hf);
        for (int i = 0; i < 16; i++) begin
            for (int v = 1; v < 4; v++) begin
                write_ok(SREG[i], 16'(v << SLSB[i]), 4'hf);
                read_expect(SREG[i], 16'(v << SLSB[i]));
                check_reqs(i, (i < 5) ? 2'(v) : 2'(v - 1));
            end
            @(posedge aclk);
            drive <= ~(16'h0001 << i);
            check_reqs(-1, 2'h0);
            @(posedge aclk);
            drive <= 16'hffff;
            write_ok(SREG[i], 16'h0000, 4'hf);
            check_reqs(-1, 2'h0);
        end
        axi_write(8'h10, 16'hffff, 4'hf, r);
        check_word("bresp", 32'h2, {30'h0, r});
        axi_read(8'h02, d, r);
        check_word("rdata", 32'h0, d);
        check_word("rresp", 32'h2, {30'h0, r});
        for (int i = 0; i < 4; i++) write_ok(i, 16'hffff, 4'hf);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 4; i++) read_expect(i, 16'h0000);
        check_reqs(-1, 2'h0);
        give_verdict();
    end

    // Whole run takes under a thousand cycles; this span is far beyond that
    initial begin
        #400000;
        n_mismatch++;
        $display("FAIL watchdog expected done seen timeout");
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
